//--- core/mba_addr_gen.sv
// Address generator end: circular wrap and reversed-carry correction
`timescale 1ns/100ps
`default_nettype none
`include "mba_consts.svh"

// How it works
// - One circular buffer each in X, Y
// - Core end disables wrapping on frame/stack pointers
// - Non-power-of-two circular buffers run one direction only
// - Power-of-two buffers check both boundaries
// - Boundary test catches overshoot, not only equality
// - Write back only for pre/post modify
// - Offset form wraps address, pointer untouched
// - Reversed carry: X writes only
// - Only the carry direction is reversed, not the operands
// - Needs select not 15, enable, pre/post increment
// - Software aligns reversed-carry buffer start
// - Fifteen-bit pivot field supplies modifier
// - Word data: pivot scaled, address bit0 cleared
// - Otherwise ordinary unreversed address generated
// - Pointer plus pivot, increment offset ignored
// - Reversed carry beats wrap in X writes
// - No read via pointer right after control write
module mba_addr_gen (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  mba_agu_if.dev           agu,
  output logic             rc_used_o,
  output logic             wrapped_o,
  output logic [15:0]      ctl_o
);

  // Bit order reversal of a full address word
  // Pure wiring, so the reversed adder costs one add
  function automatic logic [15:0] mba_rev16(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++)
      r[i] = v[15 - i];
    return r;
  endfunction : mba_rev16

  // Carry travels from the top bit downwards
  // Mirror, add, mirror back; no special adder needed
  function automatic logic [15:0] mba_rc_add(input logic [15:0] a, input logic [15:0] b);
    logic [15:0] s;
    s = 16'(mba_rev16(a) + mba_rev16(b));
    return mba_rev16(s);
  endfunction : mba_rc_add

  // Reversed-carry control word
  logic [15:0] ctl;

  // Control register fields
  wire        rc_en = ctl[`MBA_RC_EN_BIT];
  wire [14:0] pivot = ctl[`MBA_RC_PIVOT_MSB:`MBA_RC_PIVOT_LSB];

  // Addressing form decode
  wire is_plain  = (agu.mode == mba_pkg::MBA_PLAIN);
  wire is_step   = (agu.mode == mba_pkg::MBA_POST) || (agu.mode == mba_pkg::MBA_PRE);
  wire is_post   = (agu.mode == mba_pkg::MBA_POST);
  // Direction follows the modifier's sign bit
  wire is_inc    = !agu.modv[15];

  wire rc_cond   = (agu.rc_sel != `MBA_SEL_STACK) && rc_en && is_step && is_inc;
  wire rc_path   = agu.x_space && agu.write;
  // Only the designated pointer is ever reversed
  // byte writes fall back to normal
  wire rc_active = rc_cond && rc_path && !agu.byte_acc && (agu.ptr_sel == agu.rc_sel);

  wire [15:0] rc_step = {pivot, 1'b0};
  wire [15:0] rc_sum  = mba_rc_add(agu.ptr, rc_step) & `MBA_WORD_MASK;

  // Sum wraps at 16 bits like the address space
  // Ordinary sum; plain indirect uses the pointer as is
  wire [15:0] raw     = is_plain ? agu.ptr : 16'(agu.ptr + agu.modv);

  // Stack pointers arrive here already disabled
  // one buffer per space, selected by pointer
  wire x_match = agu.xmod_en && (agu.ptr_sel == agu.xmod_sel);
  wire y_match = agu.ymod_en && (agu.ptr_sel == agu.ymod_sel);
  // X reads keep wrapping; reads never reverse
  // wrap off in X writes when reversed carry runs
  wire mod_on  = !is_plain && (agu.x_space ? (x_match && !rc_active) : y_match);

  // Buffer limits of the addressed space
  // Each space keeps its own limit pair
  // End below start gives garbage; software's duty
  wire [15:0] b_start = agu.x_space ? agu.xstart : agu.ystart;
  wire [15:0] b_end   = agu.x_space ? agu.xend : agu.yend;
  wire [15:0] b_len   = 16'(b_end - b_start + `MBA_ONE);
  wire        pow2    = ((b_len & 16'(b_len - `MBA_ONE)) == 16'h0000);

  // one direction unless length is a power of two
  wire chk_up = is_inc || pow2;
  wire chk_dn = !is_inc || pow2;

  // Jumps past the end by less than one length still land inside
  // compare beyond boundary, not just equal
  wire over   = chk_up && (raw > b_end);
  wire under  = chk_dn && (raw < b_start);

  // One length per step: a jump over a whole buffer stays out
  // length taken off or added back
  wire [15:0] wrapped = over ? 16'(raw - b_len) : (under ? 16'(raw + b_len) : raw);
  wire        did_wrap = mod_on && (over || under);

  // Pointer value after modification
  wire [15:0] new_ptr = rc_active ? rc_sum : (mod_on ? wrapped : raw);

  // old pointer also loses its low bit when reversed
  // Keeps post-modify writes word aligned like the pre form
  wire [15:0] post_ea = rc_active ? (agu.ptr & `MBA_WORD_MASK) : agu.ptr;

  // Post-modify addresses with the old pointer
  wire [15:0] next_ea = is_post ? post_ea : new_ptr;

  // write back only on pre/post modify
  // offset form leaves the pointer alone
  wire next_wb_valid = agu.req && is_step;

  // Status pulses only for a request actually taken
  wire next_rc_used = agu.req && rc_active;
  wire next_wrapped = agu.req && did_wrap;

  // Mirror shows a write on the same edge as the register
  wire [15:0] next_ctl = agu.ctl_wr ? agu.ctl_wdata : ctl;

  // Control register; reads return the stored word
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ctl <= `MBA_RC_RESET;
    else if (agu.ctl_wr)
      ctl <= agu.ctl_wdata;
  end

  // Read path is the register itself, no extra delay
  assign agu.ctl_rdata = ctl;

  // Answer strobes, one cycle after the request
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      agu.ans_valid <= 1'b0;
      agu.wb_valid  <= 1'b0;
    end
    else
    begin
      agu.ans_valid <= agu.req;
      agu.wb_valid  <= next_wb_valid;
    end
  end

  // Address words; loaded every cycle, read only with a strobe
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      agu.ea     <= 16'h0000;
      agu.wb_sel <= 4'h0;
      agu.wb     <= 16'h0000;
    end
    else
    begin
      agu.ea     <= next_ea;
      agu.wb_sel <= agu.ptr_sel;
      agu.wb     <= new_ptr;
    end
  end

  // Status pulses seen by the surrounding logic
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rc_used_o <= 1'b0;
      wrapped_o <= 1'b0;
    end
    else
    begin
      rc_used_o <= next_rc_used;
      wrapped_o <= next_wrapped;
    end
  end

  // Control word mirror for the surrounding logic
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ctl_o <= `MBA_RC_RESET;
    else
      ctl_o <= next_ctl;
  end

endmodule : mba_addr_gen

`default_nettype wire

//--- core/mba_agu_if.sv
// Link between core execution and the address generator
`timescale 1ns/100ps
`default_nettype none

interface mba_agu_if;
  // Request from execution
  logic                  req;
  logic                  x_space;
  logic                  write;
  logic                  byte_acc;
  mba_pkg::mba_mode_t    mode;
  logic [3:0]            ptr_sel;
  logic [15:0]           ptr;
  logic [15:0]           modv;
  // Control register access
  logic                  ctl_wr;
  logic [15:0]           ctl_wdata;
  logic [15:0]           ctl_rdata;
  // Addressing mode configuration
  logic                  xmod_en;
  logic                  ymod_en;
  logic [3:0]            xmod_sel;
  logic [3:0]            ymod_sel;
  logic [3:0]            rc_sel;
  logic [15:0]           xstart;
  logic [15:0]           xend;
  logic [15:0]           ystart;
  logic [15:0]           yend;
  // Answer
  logic                  ans_valid;
  logic [15:0]           ea;
  logic                  wb_valid;
  logic [3:0]            wb_sel;
  logic [15:0]           wb;

  modport dev (
    input  req, x_space, write, byte_acc, mode, ptr_sel, ptr, modv,
    input  ctl_wr, ctl_wdata,
    input  xmod_en, ymod_en, xmod_sel, ymod_sel, rc_sel,
    input  xstart, xend, ystart, yend,
    output ctl_rdata, ans_valid, ea, wb_valid, wb_sel, wb
  );

  modport core (
    output req, x_space, write, byte_acc, mode, ptr_sel, ptr, modv,
    output ctl_wr, ctl_wdata,
    output xmod_en, ymod_en, xmod_sel, ymod_sel, rc_sel,
    output xstart, xend, ystart, yend,
    input  ctl_rdata, ans_valid, ea, wb_valid, wb_sel, wb
  );
endinterface : mba_agu_if

`default_nettype wire

//--- core/mba_consts.svh
// Constants for the modulo and reversed-carry address generator
`ifndef MBA_CONSTS_SVH
`define MBA_CONSTS_SVH

// Address and pointer widths
`define MBA_ADDR_W        16
`define MBA_SEL_W         4

// Reversed-carry control register layout and reset value
`define MBA_RC_EN_BIT     15
`define MBA_RC_PIVOT_MSB  14
`define MBA_RC_PIVOT_LSB  0
`define MBA_RC_RESET      16'h0000

// Pointer registers that serve the stack
`define MBA_SEL_FRAME     4'he
`define MBA_SEL_STACK     4'hf

// Word alignment mask for reversed-carry addresses
`define MBA_WORD_MASK     16'hfffe
`define MBA_ONE           16'h0001

`endif

//--- core/mba_core_end.sv
// Execution-side end: issues address requests and keeps software duties
`timescale 1ns/100ps
`default_nettype none
`include "mba_consts.svh"

module mba_core_end (
  input  wire logic                mclk_i,
  input  wire logic                rst_n_i,
  mba_agu_if.core                  agu,
  input  wire logic                usr_req_i,
  input  wire logic                usr_x_space_i,
  input  wire logic                usr_write_i,
  input  wire logic                usr_byte_i,
  input  wire mba_pkg::mba_mode_t  usr_mode_i,
  input  wire logic [3:0]          usr_ptr_sel_i,
  input  wire logic [15:0]         usr_ptr_i,
  input  wire logic [15:0]         usr_mod_i,
  input  wire logic                usr_ctl_wr_i,
  input  wire logic [15:0]         usr_ctl_wdata_i,
  input  wire logic                usr_xmod_en_i,
  input  wire logic                usr_ymod_en_i,
  input  wire logic [3:0]          usr_xmod_sel_i,
  input  wire logic [3:0]          usr_ymod_sel_i,
  input  wire logic [3:0]          usr_rc_sel_i,
  input  wire logic [15:0]         usr_xstart_i,
  input  wire logic [15:0]         usr_xend_i,
  input  wire logic [15:0]         usr_ystart_i,
  input  wire logic [15:0]         usr_yend_i,
  output logic                     usr_stall_o,
  output logic                     usr_ans_valid_o,
  output logic [15:0]              usr_ea_o,
  output logic                     usr_wb_valid_o,
  output logic [3:0]               usr_wb_sel_o,
  output logic [15:0]              usr_wb_o,
  output logic [15:0]              usr_ctl_o
);

  logic hazard_q;

  wire x_sel_ok = (usr_xmod_sel_i != `MBA_SEL_FRAME) && (usr_xmod_sel_i != `MBA_SEL_STACK);
  wire y_sel_ok = (usr_ymod_sel_i != `MBA_SEL_FRAME) && (usr_ymod_sel_i != `MBA_SEL_STACK);

  wire stall = hazard_q && usr_req_i && !usr_write_i && (usr_ptr_sel_i == usr_rc_sel_i);
  wire issue = usr_req_i && !stall;

  // Hazard armed only when reversed-carry was already on
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      hazard_q <= 1'b0;
    else
      hazard_q <= usr_ctl_wr_i && agu.ctl_rdata[`MBA_RC_EN_BIT];
  end

  // Request stage towards the generator
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      agu.req       <= 1'b0;
      agu.x_space   <= 1'b0;
      agu.write     <= 1'b0;
      agu.byte_acc  <= 1'b0;
      agu.mode      <= mba_pkg::MBA_PLAIN;
      agu.ptr_sel   <= 4'h0;
      agu.ptr       <= 16'h0000;
      agu.modv      <= 16'h0000;
      agu.ctl_wr    <= 1'b0;
      agu.ctl_wdata <= 16'h0000;
    end
    else
    begin
      agu.req       <= issue;
      agu.x_space   <= usr_x_space_i;
      agu.write     <= usr_write_i;
      agu.byte_acc  <= usr_byte_i;
      agu.mode      <= usr_mode_i;
      agu.ptr_sel   <= usr_ptr_sel_i;
      agu.ptr       <= usr_ptr_i;
      agu.modv      <= usr_mod_i;
      agu.ctl_wr    <= usr_ctl_wr_i;
      agu.ctl_wdata <= usr_ctl_wdata_i;
    end
  end

  // Configuration stage; buffer alignment is software's duty
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      agu.xmod_en  <= 1'b0;
      agu.ymod_en  <= 1'b0;
      agu.xmod_sel <= 4'h0;
      agu.ymod_sel <= 4'h0;
      agu.rc_sel   <= `MBA_SEL_STACK;
      agu.xstart   <= 16'h0000;
      agu.xend     <= 16'h0000;
      agu.ystart   <= 16'h0000;
      agu.yend     <= 16'h0000;
    end
    else
    begin
      agu.xmod_en  <= usr_xmod_en_i && x_sel_ok;
      agu.ymod_en  <= usr_ymod_en_i && y_sel_ok;
      agu.xmod_sel <= usr_xmod_sel_i;
      agu.ymod_sel <= usr_ymod_sel_i;
      agu.rc_sel   <= usr_rc_sel_i;
      agu.xstart   <= usr_xstart_i;
      agu.xend     <= usr_xend_i;
      agu.ystart   <= usr_ystart_i;
      agu.yend     <= usr_yend_i;
    end
  end

  // Answers passed back to the user side
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      usr_stall_o     <= 1'b0;
      usr_ans_valid_o <= 1'b0;
      usr_ea_o        <= 16'h0000;
      usr_wb_valid_o  <= 1'b0;
      usr_wb_sel_o    <= 4'h0;
      usr_wb_o        <= 16'h0000;
      usr_ctl_o       <= `MBA_RC_RESET;
    end
    else
    begin
      usr_stall_o     <= stall;
      usr_ans_valid_o <= agu.ans_valid;
      usr_ea_o        <= agu.ea;
      usr_wb_valid_o  <= agu.wb_valid;
      usr_wb_sel_o    <= agu.wb_sel;
      usr_wb_o        <= agu.wb;
      usr_ctl_o       <= agu.ctl_rdata;
    end
  end

endmodule : mba_core_end

`default_nettype wire

//--- core/mba_pkg.sv
// Types shared by both ends of the address generator link
package mba_pkg;

  // Indirect addressing forms
  typedef enum logic [1:0] {
    MBA_PLAIN,
    MBA_POST,
    MBA_PRE,
    MBA_OFFSET
  } mba_mode_t;

endpackage : mba_pkg

//--- dv/mba_link_asserts.sv
// Checker on the link between core end and address generator
`timescale 1ns/100ps
`default_nettype none

module mba_link_asserts (
  input wire logic               mclk_i,
  input wire logic               rst_n_i,
  input wire logic               req,
  input wire mba_pkg::mba_mode_t mode,
  input wire logic [15:0]        ptr,
  input wire logic               ctl_wr,
  input wire logic [15:0]        ctl_wdata,
  input wire logic [15:0]        ctl_rdata,
  input wire logic               ans_valid,
  input wire logic [15:0]        ea,
  input wire logic               wb_valid,
  input wire logic [15:0]        wb
);
  // One clock domain, so one default
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  // Answer timing and write-back qualification
  property p_ans; req |=> ans_valid; endproperty
  a_ans: assert property (p_ans) else $error("answer missing");
  property p_idle; !req |=> !ans_valid && !wb_valid; endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_nowb; req && mode inside {mba_pkg::MBA_PLAIN, mba_pkg::MBA_OFFSET} |=> !wb_valid;
  endproperty
  a_nowb: assert property (p_nowb) else $error("pointer written in plain or offset");
  property p_wb; req && mode inside {mba_pkg::MBA_PRE, mba_pkg::MBA_POST} |=> wb_valid;
  endproperty
  a_wb: assert property (p_wb) else $error("write-back missing");
  // Post form hands out the untouched pointer, pre form the new one
  property p_post; req && mode == mba_pkg::MBA_POST |=> ea == $past(ptr); endproperty
  a_post: assert property (p_post) else $error("post address not pointer");
  property p_pre; req && mode == mba_pkg::MBA_PRE |=> ea == wb; endproperty
  a_pre: assert property (p_pre) else $error("pre address not write-back");
  // Control register takes a write on the next edge and holds otherwise
  property p_ctl; ctl_wr |=> ctl_rdata == $past(ctl_wdata); endproperty
  a_ctl: assert property (p_ctl) else $error("control write lost");
  property p_hold; !ctl_wr |=> $stable(ctl_rdata); endproperty
  a_hold: assert property (p_hold) else $error("control changed unasked");

  // Main traffic seen
  c_post: cover property (req && mode == mba_pkg::MBA_POST);
  c_off: cover property (req && mode == mba_pkg::MBA_OFFSET);
  c_ctl: cover property (ctl_wr ##1 req);
endmodule : mba_link_asserts

`default_nettype wire

//--- dv/modulo_bitrev_address_gen_tb.sv
// Self-checking bench driving the core end against the address generator
`timescale 1ns/100ps
`default_nettype none

module modulo_bitrev_address_gen_tb;
  logic        mclk_i;
  logic        rst_n_i;
  logic        rq, xs, wr, bt, cw, xe, ye, stall, av, wv, ru, wp;
  logic [1:0]  md;
  logic [3:0]  ps, xsl, ysl, rcs, wsel;
  logic [15:0] pt, mv, cd, xst, xen, yst, yen, ea, wb, ctlo, cto;
  int          bad_count, checks, cyc;
  localparam mba_pkg::mba_mode_t PL = mba_pkg::MBA_PLAIN;
  localparam mba_pkg::mba_mode_t PO = mba_pkg::MBA_POST;
  localparam mba_pkg::mba_mode_t PR = mba_pkg::MBA_PRE;
  localparam mba_pkg::mba_mode_t OF = mba_pkg::MBA_OFFSET;

  mba_agu_if bus ();
  mba_core_end mba_core_end_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .agu(bus.core),
    .usr_req_i(rq), .usr_x_space_i(xs), .usr_write_i(wr), .usr_byte_i(bt),
    .usr_mode_i(mba_pkg::mba_mode_t'(md)), .usr_ptr_sel_i(ps), .usr_ptr_i(pt),
    .usr_mod_i(mv), .usr_ctl_wr_i(cw), .usr_ctl_wdata_i(cd), .usr_xmod_en_i(xe),
    .usr_ymod_en_i(ye), .usr_xmod_sel_i(xsl), .usr_ymod_sel_i(ysl), .usr_rc_sel_i(rcs),
    .usr_xstart_i(xst), .usr_xend_i(xen), .usr_ystart_i(yst), .usr_yend_i(yen),
    .usr_stall_o(stall), .usr_ans_valid_o(av), .usr_ea_o(ea), .usr_wb_valid_o(wv),
    .usr_wb_sel_o(wsel), .usr_wb_o(wb), .usr_ctl_o(ctlo));
  mba_addr_gen mba_addr_gen_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .agu(bus.dev),
    .rc_used_o(ru), .wrapped_o(wp), .ctl_o(cto));
  mba_link_asserts mba_link_asserts_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .req(bus.req),
    .mode(bus.mode), .ptr(bus.ptr), .ctl_wr(bus.ctl_wr), .ctl_wdata(bus.ctl_wdata),
    .ctl_rdata(bus.ctl_rdata), .ans_valid(bus.ans_valid), .ea(bus.ea),
    .wb_valid(bus.wb_valid), .wb(bus.wb));

  // Clock at 20 MHz
  always #25 mclk_i = ~mclk_i;

  // Hang guard; whole run needs under 120 cycles
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  // Config passes one flop in the core end, so let it settle
  task automatic cfg(input logic [3:0] xs_sel, input logic [3:0] rc_sel);
    @(posedge mclk_i);
    {xe, xsl, xst, xen, ye, ysl, yst, yen, rcs} <=
      {1'b1, xs_sel, 16'h1000, 16'h100f, 1'b1, 4'h5, 16'h3000, 16'h3007, rc_sel};
    repeat (3) @(posedge mclk_i);
  endtask : cfg

  task automatic wctl(input logic [15:0] d);
    @(posedge mclk_i);
    cw <= 1'b1;
    cd <= d;
    @(posedge mclk_i);
    cw <= 1'b0;
    repeat (3) @(posedge mclk_i);
    #1 chk(ctlo, d);
    chk(cto, d);
  endtask : wctl

  task automatic op(input logic x, input logic w, input logic b, input mba_pkg::mba_mode_t m,
    input logic [3:0] s, input logic [15:0] p, input logic [15:0] v,
    input logic [15:0] e_ea, input logic e_wv, input logic [15:0] e_wb, input logic [1:0] e_fl);
    int n;
    logic [1:0] fl;
    n = 0;
    fl = 2'b00;
    @(posedge mclk_i);
    {rq, xs, wr, bt, md, ps, pt, mv} <= {1'b1, x, w, b, m, s, p, v};
    @(posedge mclk_i);
    rq <= 1'b0;
    // Status pulses stand a cycle ahead of the answer, so gather them
    do
    begin
      @(posedge mclk_i);
      #1 n++;
      fl = fl | {ru === 1'b1, wp === 1'b1};
    end while (av !== 1'b1 && n < 6);
    chk({15'h0, av}, 16'h0001);
    chk(ea, e_ea);
    chk({15'h0, wv}, {15'h0, e_wv});
    if (e_wv)
    begin
      chk(wb, e_wb);
      chk({12'h0, wsel}, {12'h0, s});
    end
    chk({14'h0, fl}, {14'h0, e_fl});
  endtask : op

  task automatic t_modulo();
    cfg(4'h3, 4'hf);
    op(1, 0, 0, PL, 4'h3, 16'h100c, 16'h0008, 16'h100c, 0, 16'h0, 2'b00);
    op(1, 0, 0, OF, 4'h3, 16'h100c, 16'h0008, 16'h1004, 0, 16'h0, 2'b01);
    op(1, 0, 0, PO, 4'h3, 16'h100e, 16'h0004, 16'h100e, 1, 16'h1002, 2'b01);
    op(1, 1, 0, PR, 4'h3, 16'h1002, 16'hfffc, 16'h100e, 1, 16'h100e, 2'b01);
    op(0, 0, 0, PO, 4'h5, 16'h3006, 16'h0002, 16'h3006, 1, 16'h3000, 2'b01);
    op(1, 0, 0, PO, 4'h4, 16'h100e, 16'h0004, 16'h100e, 1, 16'h1012, 2'b00);
    // Frame pointer picked for wrapping is never enabled
    cfg(4'he, 4'hf);
    op(1, 0, 0, PO, 4'he, 16'h100e, 16'h0004, 16'h100e, 1, 16'h1012, 2'b00);
  endtask : t_modulo

  // buffer placed at 16'h2000, low bits clear
  // Pivot 4 scales to a byte step of 8, added with carry running down
  task automatic t_revcarry();
    wctl(16'h8004);
    cfg(4'h3, 4'h2);
    op(1, 1, 0, PO, 4'h2, 16'h2000, 16'h0002, 16'h2000, 1, 16'h2008, 2'b10);
    op(1, 1, 0, PR, 4'h2, 16'h2009, 16'h0002, 16'h2004, 1, 16'h2004, 2'b10);
    op(1, 1, 1, PO, 4'h2, 16'h2000, 16'h0002, 16'h2000, 1, 16'h2002, 2'b00);
    op(1, 0, 0, PO, 4'h2, 16'h2000, 16'h0002, 16'h2000, 1, 16'h2002, 2'b00);
    op(0, 1, 0, PO, 4'h2, 16'h2000, 16'h0002, 16'h2000, 1, 16'h2002, 2'b00);
    op(1, 1, 0, OF, 4'h2, 16'h2000, 16'h0002, 16'h2002, 0, 16'h0, 2'b00);
    cfg(4'h3, 4'hf);
    op(1, 1, 0, PO, 4'h2, 16'h2000, 16'h0002, 16'h2000, 1, 16'h2002, 2'b00);
  endtask : t_revcarry

  // Both modes on one pointer: writes reverse, reads still wrap
  task automatic t_prio();
    cfg(4'h2, 4'h2);
    op(1, 1, 0, PO, 4'h2, 16'h100e, 16'h0004, 16'h100e, 1, 16'h1000, 2'b10);
    op(1, 0, 0, PO, 4'h2, 16'h100e, 16'h0004, 16'h100e, 1, 16'h1002, 2'b01);
  endtask : t_prio

  // Read through the reversed pointer straight after a control write
  task automatic t_stall();
    logic s_seen, a_seen;
    s_seen = 0;
    a_seen = 0;
    @(posedge mclk_i);
    cw <= 1'b1;
    @(posedge mclk_i);
    cw <= 1'b0;
    {rq, xs, wr, bt, md, ps, pt, mv} <= {1'b1, 1'b1, 1'b0, 1'b0, PO, 4'h2, 16'h2000, 16'h2};
    // Stall flag stands only in the cycle after the dropped read
    repeat (6)
    begin
      @(posedge mclk_i);
      rq <= 1'b0;
      #1 s_seen |= (stall === 1'b1);
      a_seen |= (av === 1'b1);
    end
    chk({15'h0, s_seen}, 16'h0001);
    chk({15'h0, a_seen}, 16'h0000);
  endtask : t_stall

  // Reset, then scenarios in turn
  initial
  begin
    mclk_i = 0;
    rst_n_i = 0;
    {rq, xs, wr, bt, md, ps, pt, mv, cw, cd} = '0;
    {xe, xsl, xst, xen, ye, ysl, yst, yen, rcs} = '0;
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    t_modulo();
    t_revcarry();
    wctl(16'h8004);
    t_prio();
    t_stall();
    conclude();
  end
endmodule : modulo_bitrev_address_gen_tb

`default_nettype wire
